// ==== common/scer_map.svh ====
// Offsets-free constants of the status condition and event register bank
`ifndef SCER_MAP_SVH
`define SCER_MAP_SVH

// Operation bit positions
`define SCER_OP_LIST_RUNNING      14
`define SCER_OP_LIST_COMPLETE     12
`define SCER_OP_SAMPLE_COMPLETE   11
`define SCER_OP_CONST_CURRENT     10
`define SCER_OP_TRANS_COMPLETE    9
`define SCER_OP_CONST_VOLTAGE     8
`define SCER_OP_TRANS_ARMED       6
`define SCER_OP_WAIT_TRIGGER      5

// Questionable bit positions
`define SCER_QU_ENERGY_SINKING    14
`define SCER_QU_CURRENT_ERROR     13
`define SCER_QU_VOLTAGE_ERROR     12
`define SCER_QU_FOLLOWER_ERROR    6
`define SCER_QU_THERMAL_ERROR     3
`define SCER_QU_CURRENT_MODE_ERR  1
`define SCER_QU_VOLTAGE_MODE_ERR  0

// Used-bit masks and the subset of questionable bits that latch
`define SCER_OP_USED_BITS         16'h5f60
`define SCER_QU_USED_BITS         16'h704b
`define SCER_QU_LATCH_BITS        16'h3000

// Preset and reset values of the summary masks
`define SCER_OP_MASK_PRESET       16'h2001
`define SCER_QU_MASK_PRESET       16'h00ff
`define SCER_OP_MASK_RESET        16'h0000
`define SCER_QU_MASK_RESET        16'h0000

`endif

// ==== common/scer_pkg.sv ====
// Types shared by the status condition and event register bank
package scer_pkg;

  typedef enum logic [3:0] {
    SCER_CMD_OPER_COND_RD = 4'h0,
    SCER_CMD_OPER_MASK_WR = 4'h1,
    SCER_CMD_OPER_MASK_RD = 4'h2,
    SCER_CMD_OPER_EVT_RD  = 4'h3,
    SCER_CMD_PRESET       = 4'h4,
    SCER_CMD_QUES_EVT_RD  = 4'h5,
    SCER_CMD_QUES_COND_RD = 4'h6,
    SCER_CMD_QUES_MASK_WR = 4'h7,
    SCER_CMD_QUES_MASK_RD = 4'h8
  } scer_cmd_t;

  typedef struct packed {
    logic list_running;
    logic list_complete;
    logic sample_complete;
    logic constant_current_mode;
    logic transient_complete;
    logic constant_voltage_mode;
    logic transient_armed;
    logic waiting_for_trigger;
  } scer_oper_t;

  typedef struct packed {
    logic energy_sinking;
    logic current_error;
    logic voltage_error;
    logic follower_unit_error;
    logic thermal_error;
    logic current_mode_error;
    logic voltage_mode_error;
  } scer_ques_t;

  typedef struct packed {
    logic      valid;
    scer_cmd_t code;
    logic [15:0] wdata;
  } scer_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] rdata;
  } scer_rsp_t;

endpackage : scer_pkg

// ==== design/scer_regs.sv ====
// Operation and questionable status register bank with summary bits
`timescale 1ns/1ps
`include "scer_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Operation condition word mirrors live operating state; query returns it.
// - Operation bits: list 14/12, sample 11, CC 10, transient 9, CV 8, 6, 5.
// - One means active or true, zero means inactive or false.
// - Status byte bit 7 is OR of operation events under the operation mask.
// - Reading the operation mask returns exactly what was stored.
// - Operation events latch condition onsets; reading returns then clears them.
// - Preset loads operation mask 8193 and questionable mask 255.
// - Questionable events hold latched events; reading returns then clears them.
// - Only questionable bits 13 and 12 latch; bits 0 and 1 never latch.
// - Questionable bits: sinking 14, errors 13/12/6/3, mode errors 1 and 0.
// - Questionable condition word mirrors live state; query returns it.
// - Questionable bits 1 and 0 may both be set while output settles.
// - Status byte bit 3 is OR of questionable events under questionable mask.
module scer_regs
  import scer_pkg::*;
#(
  parameter int REG_W = 16
)
(
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Live conditions from the supply logic, same clock
  input  wire scer_oper_t oper_live,
  input  wire scer_ques_t ques_live,
  // Host command and answer
  input  wire scer_req_t  req,
  output      scer_rsp_t  rsp,
  // Status byte summary bits
  output      logic       stb_oper_summary,
  output      logic       stb_ques_summary
);

  if (REG_W != 16) begin : g_width_check
    $error("scer_regs supports only 16-bit status registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit placement
  function automatic logic [15:0] oper_word(input scer_oper_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`SCER_OP_LIST_RUNNING]    = c.list_running;
    w[`SCER_OP_LIST_COMPLETE]   = c.list_complete;
    w[`SCER_OP_SAMPLE_COMPLETE] = c.sample_complete;
    w[`SCER_OP_CONST_CURRENT]   = c.constant_current_mode;
    w[`SCER_OP_TRANS_COMPLETE]  = c.transient_complete;
    w[`SCER_OP_CONST_VOLTAGE]   = c.constant_voltage_mode;
    w[`SCER_OP_TRANS_ARMED]     = c.transient_armed;
    w[`SCER_OP_WAIT_TRIGGER]    = c.waiting_for_trigger;
    return w & `SCER_OP_USED_BITS;
  endfunction : oper_word

  function automatic logic [15:0] ques_word(input scer_ques_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`SCER_QU_ENERGY_SINKING]   = c.energy_sinking;
    w[`SCER_QU_CURRENT_ERROR]    = c.current_error;
    w[`SCER_QU_VOLTAGE_ERROR]    = c.voltage_error;
    w[`SCER_QU_FOLLOWER_ERROR]   = c.follower_unit_error;
    w[`SCER_QU_THERMAL_ERROR]    = c.thermal_error;
    w[`SCER_QU_CURRENT_MODE_ERR] = c.current_mode_error;
    w[`SCER_QU_VOLTAGE_MODE_ERR] = c.voltage_mode_error;
    return w & `SCER_QU_USED_BITS;
  endfunction : ques_word

  // Events are onsets of a condition, so a held condition reports once
  function automatic logic [15:0] onset(input logic [15:0] now_v,
                                        input logic [15:0] was_v);
    return now_v & ~was_v;
  endfunction : onset

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] oper_cond_reg, oper_cond_next;
  logic [15:0] ques_cond_reg, ques_cond_next;
  logic [15:0] oper_mask_reg, oper_mask_next;
  logic [15:0] ques_mask_reg, ques_mask_next;
  logic [15:0] oper_evt_reg,  oper_evt_next;
  logic [15:0] ques_evt_reg,  ques_evt_next;
  scer_rsp_t   rsp_reg,       rsp_next;

  logic        cmd_hit;
  logic [15:0] oper_live_w;
  logic [15:0] ques_live_w;

  assign oper_live_w = oper_word(oper_live);
  assign ques_live_w = ques_word(ques_live);

  always_comb
  begin
    cmd_hit        = req.valid;
    oper_cond_next = oper_live_w;
    ques_cond_next = ques_live_w;
    oper_mask_next = oper_mask_reg;
    ques_mask_next = ques_mask_reg;
    // Set beats clear: an onset in the read cycle survives into the next read
    oper_evt_next  = oper_evt_reg | onset(oper_live_w, oper_cond_reg);
    ques_evt_next  = ques_evt_reg
                   | (onset(ques_live_w, ques_cond_reg) & `SCER_QU_LATCH_BITS);
    rsp_next       = '0;
    if (cmd_hit)
    begin
      rsp_next.valid = 1'b1;
      case (req.code)
        SCER_CMD_OPER_COND_RD: rsp_next.rdata = oper_cond_reg;
        SCER_CMD_QUES_COND_RD: rsp_next.rdata = ques_cond_reg;
        SCER_CMD_OPER_MASK_WR: oper_mask_next = req.wdata;
        SCER_CMD_QUES_MASK_WR: ques_mask_next = req.wdata;
        SCER_CMD_OPER_MASK_RD: rsp_next.rdata = oper_mask_reg;
        SCER_CMD_QUES_MASK_RD: rsp_next.rdata = ques_mask_reg;
        SCER_CMD_OPER_EVT_RD:
        begin
          rsp_next.rdata = oper_evt_reg;
          oper_evt_next  = onset(oper_live_w, oper_cond_reg);
        end
        SCER_CMD_QUES_EVT_RD:
        begin
          rsp_next.rdata = ques_evt_reg;
          ques_evt_next  = onset(ques_live_w, ques_cond_reg) & `SCER_QU_LATCH_BITS;
        end
        SCER_CMD_PRESET:
        begin
          oper_mask_next = `SCER_OP_MASK_PRESET;
          ques_mask_next = `SCER_QU_MASK_PRESET;
        end
        default: rsp_next.error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      oper_cond_reg <= 16'h0000;
      ques_cond_reg <= 16'h0000;
      oper_mask_reg <= `SCER_OP_MASK_RESET;
      ques_mask_reg <= `SCER_QU_MASK_RESET;
      oper_evt_reg  <= 16'h0000;
      ques_evt_reg  <= 16'h0000;
      rsp_reg       <= '0;
    end
    else if (ce)
    begin
      oper_cond_reg <= oper_cond_next;
      ques_cond_reg <= ques_cond_next;
      oper_mask_reg <= oper_mask_next;
      ques_mask_reg <= ques_mask_next;
      oper_evt_reg  <= oper_evt_next;
      ques_evt_reg  <= ques_evt_next;
      rsp_reg       <= rsp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; events hold zeros in unused bits, so stray mask bits are inert
  assign rsp              = rsp_reg;
  assign stb_oper_summary = |(oper_evt_reg & oper_mask_reg);
  assign stb_ques_summary = |(ques_evt_reg & ques_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  oper_cond_read_a: assert property (ce && req.valid && req.code == SCER_CMD_OPER_COND_RD
    |=> rsp.valid && rsp.rdata == $past(oper_cond_reg))
    else $error("operation condition read wrong");
  oper_cond_map_a: assert property (ce |=> oper_cond_reg[10] == $past(oper_live.constant_current_mode)
    && oper_cond_reg[8] == $past(oper_live.constant_voltage_mode) && oper_cond_reg[14] == $past(oper_live.list_running))
    else $error("operation bit placement wrong");
  oper_summary_a: assert property (stb_oper_summary == |(oper_evt_reg & oper_mask_reg & `SCER_OP_USED_BITS))
    else $error("operation summary wrong");
  mask_readback_a: assert property (ce && req.valid && req.code == SCER_CMD_OPER_MASK_WR ##1
    ce && req.valid && req.code == SCER_CMD_OPER_MASK_RD |=> rsp.rdata == $past(req.wdata, 2))
    else $error("operation mask readback wrong");
  oper_evt_clear_a: assert property (ce && req.valid && req.code == SCER_CMD_OPER_EVT_RD
    |=> oper_evt_reg == onset($past(oper_live_w), $past(oper_cond_reg)))
    else $error("operation event not cleared by read");
  oper_evt_latch_a: assert property (ce && oper_live.constant_current_mode && !oper_cond_reg[10]
    |=> oper_evt_reg[10])
    else $error("operation onset lost");
  preset_masks_a: assert property (ce && req.valid && req.code == SCER_CMD_PRESET
    |=> oper_mask_reg == 16'h2001 && ques_mask_reg == 16'h00ff)
    else $error("preset masks wrong");
  ques_evt_clear_a: assert property (ce && req.valid && req.code == SCER_CMD_QUES_EVT_RD
    |=> rsp.rdata == $past(ques_evt_reg) && (ques_evt_reg & ~`SCER_QU_LATCH_BITS) == 16'h0000)
    else $error("questionable event read wrong");
  ques_latch_only_a: assert property ((ques_evt_reg & ~`SCER_QU_LATCH_BITS) == 16'h0000)
    else $error("questionable latch beyond bits 13 and 12");
  ques_cond_read_a: assert property (ce && req.valid && req.code == SCER_CMD_QUES_COND_RD
    |=> rsp.rdata == $past(ques_cond_reg) && (rsp.rdata & ~`SCER_QU_USED_BITS) == 16'h0000)
    else $error("questionable condition read wrong");
  ques_summary_a: assert property (stb_ques_summary == |(ques_evt_reg & ques_mask_reg))
    else $error("questionable summary wrong");
  unused_zero_a: assert property ((oper_cond_reg & ~`SCER_OP_USED_BITS) == 16'h0000
    && (oper_evt_reg & ~`SCER_OP_USED_BITS) == 16'h0000)
    else $error("unused operation bits set");
  ques_cond_map_a: assert property (ce |=> ques_cond_reg[14] == $past(ques_live.energy_sinking)
    && ques_cond_reg[6] == $past(ques_live.follower_unit_error)
    && ques_cond_reg[3] == $past(ques_live.thermal_error))
    else $error("questionable bit placement wrong");
  settle_pair_a: assert property (ce |=> ques_cond_reg[1:0] == {$past(ques_live.current_mode_error),
    $past(ques_live.voltage_mode_error)})
    else $error("settling bits not mirrored");
  // A frozen bank must not lose or invent events while the enable is low
  ce_freeze_a: assert property (!ce |=> $stable(oper_evt_reg) && $stable(ques_evt_reg)
    && $stable(oper_mask_reg) && $stable(ques_mask_reg) && $stable(rsp))
    else $error("state moved while clock enable low");

  settle_c:    cover property (ques_cond_reg[1] && ques_cond_reg[0]);
  preset_c:    cover property (ce && req.valid && req.code == SCER_CMD_PRESET);
  op_sum_c:    cover property (stb_oper_summary ##1 !stb_oper_summary);
  set_clear_c: cover property (ce && req.valid && req.code == SCER_CMD_QUES_EVT_RD
    && |(onset(ques_live_w, ques_cond_reg) & `SCER_QU_LATCH_BITS));
  freeze_c:    cover property (!ce ##1 ce);

endmodule : scer_regs

// ==== verif/scer_host_model.sv ====
// Host model issuing status queries and commands
`timescale 1ns/1ps
module scer_host_model
  import scer_pkg::*;
(
  // Clock
  input  wire logic      clk,
  // Command port
  output      scer_req_t req,
  input  wire scer_rsp_t rsp
);
  initial req = '0;

  // One-cycle request pulse; the answer is taken just after the taking edge
  task automatic xfer(input scer_cmd_t code, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic err, output logic ok);
    int n;
    @(posedge clk);
    req <= '{valid: 1'b1, code: code, wdata: wdata};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (rsp.valid === 1'b1) && (n == 0);
    rdata = rsp.rdata;
    err = rsp.error;
  endtask : xfer

  // Two requests on consecutive edges; the second answer is taken as it stands
  task automatic xfer_pair(input scer_cmd_t c0, input logic [15:0] w0, input scer_cmd_t c1,
                           output logic [15:0] r1);
    @(posedge clk);
    req <= '{valid: 1'b1, code: c0, wdata: w0};
    @(posedge clk);
    req <= '{valid: 1'b1, code: c1, wdata: 16'h0000};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    r1 = rsp.rdata;
  endtask : xfer_pair
endmodule : scer_host_model

// ==== verif/status_condition_event_regs_test.sv ====
// Self-checking bench for the status condition and event register bank
`timescale 1ns/1ps
module status_condition_event_regs_test;
  import scer_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        ce;
  scer_oper_t  oper_live;
  scer_ques_t  ques_live;
  scer_req_t   req;
  scer_rsp_t   rsp;
  logic        stb_oper_summary;
  logic        stb_ques_summary;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [15:0] rd;
  logic [15:0] w;
  logic        er;
  logic        ok;

  scer_regs #(.REG_W(16)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .oper_live(oper_live),
    .ques_live(ques_live), .req(req), .rsp(rsp), .stb_oper_summary(stb_oper_summary),
    .stb_ques_summary(stb_ques_summary));
  scer_host_model host_u (.clk(clk), .req(req), .rsp(rsp));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Every command must answer exactly one cycle later without error
  task automatic cmd(input scer_cmd_t c, input logic [15:0] wd, input logic [15:0] exp);
    host_u.xfer(c, wd, rd, er, ok);
    chk({14'h0, ok, er}, 16'h0002);
    chk(rd, exp);
  endtask : cmd

  task automatic sums(input logic op, input logic qu);
    chk({14'h0, stb_oper_summary, stb_ques_summary}, {14'h0, op, qu});
  endtask : sums

  // Word bits outside the used positions have no live source
  task automatic live(input logic [15:0] op, input logic [15:0] qu);
    @(posedge clk);
    oper_live <= {op[14], op[12], op[11], op[10], op[9], op[8], op[6], op[5]};
    ques_live <= {qu[14], qu[13], qu[12], qu[6], qu[3], qu[1], qu[0]};
    repeat (2) @(posedge clk);
    #1;
  endtask : live

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    oper_live = '0;
    ques_live = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cmd(SCER_CMD_OPER_MASK_RD, 16'h0, 16'h0);
    cmd(SCER_CMD_QUES_MASK_RD, 16'h0, 16'h0);
    cmd(SCER_CMD_OPER_EVT_RD, 16'h0, 16'h0);
    sums(1'b0, 1'b0);
    $display("test reset done");
    for (int b = 0; b < 16; b++)
    begin
      w = 16'h0001 << b;
      live(w, w);
      cmd(SCER_CMD_OPER_COND_RD, 16'h0, w & 16'h5f60);
      cmd(SCER_CMD_QUES_COND_RD, 16'h0, w & 16'h704b);
    end
    live(16'h5f60, 16'h704b);
    cmd(SCER_CMD_QUES_COND_RD, 16'h0, 16'h704b);
    live(16'h0, 16'h0);
    cmd(SCER_CMD_OPER_COND_RD, 16'h0, 16'h0);
    $display("test conditions done");
    cmd(SCER_CMD_OPER_EVT_RD, 16'h0, 16'h5f60);
    cmd(SCER_CMD_OPER_EVT_RD, 16'h0, 16'h0);
    cmd(SCER_CMD_QUES_EVT_RD, 16'h0, 16'h3000);
    cmd(SCER_CMD_QUES_EVT_RD, 16'h0, 16'h0);
    $display("test events done");
    cmd(SCER_CMD_OPER_MASK_WR, 16'hffff, 16'h0);
    cmd(SCER_CMD_OPER_MASK_RD, 16'h0, 16'hffff);
    live(16'h0400, 16'h0);
    sums(1'b1, 1'b0);
    cmd(SCER_CMD_OPER_MASK_WR, 16'hfbff, 16'h0);
    sums(1'b0, 1'b0);
    cmd(SCER_CMD_OPER_EVT_RD, 16'h0, 16'h0400);
    cmd(SCER_CMD_QUES_MASK_WR, 16'h2000, 16'h0);
    // A frozen bank must not take the onset until the enable returns
    @(posedge clk);
    ce <= 1'b0;
    live(16'h0, 16'h2000);
    sums(1'b0, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    sums(1'b0, 1'b1);
    cmd(SCER_CMD_QUES_EVT_RD, 16'h0, 16'h2000);
    sums(1'b0, 1'b0);
    cmd(SCER_CMD_OPER_MASK_WR, 16'ha09f, 16'h0);
    live(16'h5f60, 16'h0);
    sums(1'b0, 1'b0);
    $display("test summaries done");
    host_u.xfer_pair(SCER_CMD_OPER_MASK_WR, 16'h1234, SCER_CMD_OPER_MASK_RD, rd);
    chk(rd, 16'h1234);
    $display("test back to back done");
    cmd(SCER_CMD_PRESET, 16'h0, 16'h0);
    cmd(SCER_CMD_OPER_MASK_RD, 16'h0, 16'h2001);
    cmd(SCER_CMD_QUES_MASK_RD, 16'h0, 16'h00ff);
    $display("test preset done");
    for (int c = 9; c < 16; c++)
    begin
      host_u.xfer(scer_cmd_t'(c[3:0]), 16'hffff, rd, er, ok);
      chk({14'h0, ok, er}, 16'h0003);
      chk(rd, 16'h0);
    end
    cmd(SCER_CMD_OPER_MASK_RD, 16'h0, 16'h2001);
    $display("test refused codes done");
    // Conditions held through a reset show up as fresh onsets
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    cmd(SCER_CMD_QUES_MASK_RD, 16'h0, 16'h0);
    cmd(SCER_CMD_OPER_EVT_RD, 16'h0, 16'h5f60);
    $display("test second reset done");
    wrap_up();
  end

  // Whole run is a few hundred cycles; this cuts a hang well after that
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule : status_condition_event_regs_test
